/* shared/adcris_pkg.sv */
// How it works
// R1: Each 12-bit result is held behind two byte-wide result registers that software can only read.
// R2: Format 0 puts result bits 11..4 in the high byte and bits 3..0 in low bits 7..4; format 1 puts bits 11..8 in high bits 3..0 and bits 7..0 in the low byte.
// R3: Result bit positions not used by the chosen format read as zero.
// R4: While the converter is disabled both result registers keep their contents.
// R5: A four-bit channel field in the main control register picks the external input for the one converter.
// R6: A four-bit source field in the second control register picks the external channel or an internal supply or amplifier signal.
// R7: A pin assigned as a converter input loses its general I/O and other shared functions.
// R8: A pin assigned as a converter input has its pull-up switched off.
// R9: A single bit in the bandgap register switches the bandgap reference on or off.
// R10: A conversion starts only after the start bit is written 0, then 1, then back to 0.
// R11: The read-only busy flag rises when a conversion starts and clears when it completes.
// R12: Channel codes 0,1 and 3..8 select inputs 0,1 and 3..8; 2 and 9..11 are reserved; 12..15 float.
// R13: Source codes 0, 4 and 12..15 pick the external channel, 1..3 supply /1 /2 /4, 5..7 amplifier /1 /2 /4, 10xx ground.
// R14: Both result bytes change together, in one cycle, when a conversion completes.
package adcris_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_RESULT_LOW   = 8'h00;
    localparam logic [7:0] OFS_RESULT_HIGH  = 8'h04;
    localparam logic [7:0] OFS_CONTROL_MAIN = 8'h08;
    localparam logic [7:0] OFS_SOURCE_CLOCK = 8'h0c;
    localparam logic [7:0] OFS_AMP_REF      = 8'h10;
    localparam logic [7:0] OFS_BANDGAP      = 8'h14;
    localparam logic [7:0] OFS_PIN_ASSIGN   = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int START_BIT   = 7;
    localparam int BUSY_BIT    = 6;
    localparam int ENABLE_BIT  = 5;
    localparam int FORMAT_BIT  = 4;
    localparam int CHANNEL_LSB = 0;
    localparam int SOURCE_LSB  = 4;
    localparam int CLKDIV_LSB  = 0;
    localparam int BANDGAP_BIT = 0;
    localparam int AMP_EN_BIT  = 7;

    // Writable bits of the amplifier/reference register
    localparam logic [7:0] AMP_REF_MASK = 8'h9f;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_CONTROL_MAIN = 8'h00;
    localparam logic [7:0]  RST_SOURCE_CLOCK = 8'h00;
    localparam logic [7:0]  RST_AMP_REF      = 8'h00;
    localparam logic        RST_BANDGAP      = 1'b0;
    localparam logic [11:0] RST_RESULT       = 12'h000;

    // ------------------------------------------------------------
    // Codes and bus answers
    // ------------------------------------------------------------
    localparam logic [3:0] CHAN_RESERVED = 4'h2;
    localparam logic [3:0] CHAN_LAST     = 4'h8;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    typedef enum logic {
        ADCRIS_IDLE,
        ADCRIS_CONVERT
    } adcris_state_e;

endpackage

/* logic/adcris_result_fmt.sv */
`timescale 1ns/1ps
`default_nettype none

module adcris_result_fmt (
    // Clock for the checks
    input  wire logic        clk,
    input  wire logic        rst,
    // Stored result and format
    input  wire logic [11:0] result,
    input  wire logic        format_sel,
    // Register views
    output logic      [7:0]  result_high,
    output logic      [7:0]  result_low
);

    // ------------------------------------------------------------
    // Byte placement
    // ------------------------------------------------------------
    wire [7:0] high_left  = result[11:4];
    wire [7:0] low_left   = {result[3:0], 4'h0};
    wire [7:0] high_right = {4'h0, result[11:8]};
    wire [7:0] low_right  = result[7:0];

    assign result_high = format_sel ? high_right : high_left; // R2 R3
    assign result_low  = format_sel ? low_right  : low_left;  // R2 R3

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_left_layout: assert property ( // R2
        !format_sel |-> {result_high, result_low[7:4]} == result)
        else $error("left-justified layout wrong");

    chk_right_layout: assert property ( // R2
        format_sel |-> {result_high[3:0], result_low} == result)
        else $error("right-justified layout wrong");

    chk_pad_zero: assert property ( // R3
        (format_sel ? result_high[7:4] : result_low[3:0]) == 4'h0)
        else $error("unused result bits not zero");

endmodule

`default_nettype wire

/* logic/adcris_top.sv */
`timescale 1ns/1ps
`default_nettype none

module adcris_top #(
    parameter int NUM_PINS = 9
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // AXI4-Lite write address
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [7:0]          s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    // AXI4-Lite write response
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic      [1:0]          s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [7:0]          s_axi_araddr,
    // AXI4-Lite read data
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic      [31:0]         s_axi_rdata,
    output logic      [1:0]          s_axi_rresp,
    // Analog converter core
    output logic                     conv_start,
    output logic                     converter_enable,
    input  wire logic                conv_done,
    input  wire logic [11:0]         conv_data,
    output logic      [2:0]          conv_clock_divider_field,
    // Input routing
    output logic      [NUM_PINS-1:0] channel_route,
    output logic                     sel_external,
    output logic                     sel_supply,
    output logic                     sel_amp,
    output logic                     sel_ground,
    output logic      [1:0]          sel_divide_log2,
    // Amplifier and references
    output logic                     amp_enable_bit,
    output logic      [6:0]          amp_reference_output,
    output logic                     bandgap_enable_bit,
    // Pin takeover
    input  wire logic [NUM_PINS-1:0] pullup_request,
    output logic      [NUM_PINS-1:0] pullup_enable,
    output logic      [NUM_PINS-1:0] digital_connect
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic                start_bit;
    logic                conversion_busy_flag;
    logic                conv_en;
    logic                result_format_select;
    logic [3:0]          external_channel_field;
    logic [3:0]          signal_source_field;
    logic [2:0]          clkdiv;
    logic [7:0]          amp_ref;
    logic                bandgap;
    logic [NUM_PINS-1:0] analog_input_pin;
    logic [11:0]         result;
    adcris_pkg::adcris_state_e state;
    adcris_pkg::adcris_state_e next_state;

    // ------------------------------------------------------------
    // Write channel holding
    // ------------------------------------------------------------
    logic        aw_held;
    logic        w_held;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    wire wr_fire  = aw_held & w_held & ~s_axi_bvalid;
    wire lane0    = wr_strb[0];
    wire lane1    = wr_strb[1];
    wire wr_ctrl  = wr_fire & lane0 & (wr_addr == adcris_pkg::OFS_CONTROL_MAIN);
    wire wr_src   = wr_fire & lane0 & (wr_addr == adcris_pkg::OFS_SOURCE_CLOCK);
    wire wr_amp   = wr_fire & lane0 & (wr_addr == adcris_pkg::OFS_AMP_REF);
    wire wr_bgap  = wr_fire & lane0 & (wr_addr == adcris_pkg::OFS_BANDGAP);
    wire wr_pin   = wr_fire & (wr_addr == adcris_pkg::OFS_PIN_ASSIGN);
    wire wr_known = (wr_addr == adcris_pkg::OFS_RESULT_LOW)
                  | (wr_addr == adcris_pkg::OFS_RESULT_HIGH)
                  | (wr_addr == adcris_pkg::OFS_CONTROL_MAIN)
                  | (wr_addr == adcris_pkg::OFS_SOURCE_CLOCK)
                  | (wr_addr == adcris_pkg::OFS_AMP_REF)
                  | (wr_addr == adcris_pkg::OFS_BANDGAP)
                  | (wr_addr == adcris_pkg::OFS_PIN_ASSIGN);
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held <= 1'b0;
            wr_addr <= 8'h00;
        end else if (s_axi_awvalid & ~aw_held) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            w_held  <= 1'b0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else if (s_axi_wvalid & ~w_held) begin
            w_held  <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= adcris_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? adcris_pkg::RESP_OKAY : adcris_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    wire [7:0] wd          = wr_data[7:0];
    wire       wd_start    = wd[adcris_pkg::START_BIT];
    wire       wd_enable   = wd[adcris_pkg::ENABLE_BIT];
    wire       start_fall  = wr_ctrl & start_bit & ~wd_start;          // R10
    wire       begin_conv  = start_fall & wd_enable & (state == adcris_pkg::ADCRIS_IDLE); // R10
    wire       finish_conv = (state == adcris_pkg::ADCRIS_CONVERT) & conv_done;

    always_ff @(posedge clk) begin
        if (rst) begin
            start_bit              <= adcris_pkg::RST_CONTROL_MAIN[adcris_pkg::START_BIT];
            conv_en                <= adcris_pkg::RST_CONTROL_MAIN[adcris_pkg::ENABLE_BIT];
            result_format_select   <= adcris_pkg::RST_CONTROL_MAIN[adcris_pkg::FORMAT_BIT];
            external_channel_field <= adcris_pkg::RST_CONTROL_MAIN[3:0];
        end else if (wr_ctrl) begin
            start_bit              <= wd_start;
            conv_en                <= wd_enable;
            result_format_select   <= wd[adcris_pkg::FORMAT_BIT];
            external_channel_field <= wd[adcris_pkg::CHANNEL_LSB +: 4]; // R5
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            signal_source_field <= adcris_pkg::RST_SOURCE_CLOCK[adcris_pkg::SOURCE_LSB +: 4];
            clkdiv              <= adcris_pkg::RST_SOURCE_CLOCK[adcris_pkg::CLKDIV_LSB +: 3];
        end else if (wr_src) begin
            signal_source_field <= wd[adcris_pkg::SOURCE_LSB +: 4]; // R6
            clkdiv              <= wd[adcris_pkg::CLKDIV_LSB +: 3];
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            amp_ref <= adcris_pkg::RST_AMP_REF;
        end else if (wr_amp) begin
            amp_ref <= wd & adcris_pkg::AMP_REF_MASK;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            bandgap <= adcris_pkg::RST_BANDGAP;
        end else if (wr_bgap) begin
            bandgap <= wd[adcris_pkg::BANDGAP_BIT]; // R9
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            analog_input_pin <= '0;
        end else if (wr_pin) begin
            if (lane0) begin
                analog_input_pin[7:0] <= wd;
            end
            if (lane1) begin
                analog_input_pin[NUM_PINS-1:8] <= wr_data[NUM_PINS-1:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            adcris_pkg::ADCRIS_IDLE: begin
                if (begin_conv) begin
                    next_state = adcris_pkg::ADCRIS_CONVERT;
                end
            end
            adcris_pkg::ADCRIS_CONVERT: begin
                if (conv_done | ~conv_en) begin
                    next_state = adcris_pkg::ADCRIS_IDLE;
                end
            end
            default: next_state = adcris_pkg::ADCRIS_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= adcris_pkg::ADCRIS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            conversion_busy_flag <= 1'b0;
            conv_start           <= 1'b0;
        end else begin
            conv_start           <= begin_conv;
            conversion_busy_flag <= (next_state == adcris_pkg::ADCRIS_CONVERT); // R11
        end
    end

    // Whole word latched at once so both byte views change together
    always_ff @(posedge clk) begin
        if (rst) begin
            result <= adcris_pkg::RST_RESULT;
        end else if (finish_conv & conv_en) begin // R4 R14
            result <= conv_data;
        end
    end

    // ------------------------------------------------------------
    // Result byte views
    // ------------------------------------------------------------
    logic [7:0] res_high;
    logic [7:0] res_low;

    adcris_result_fmt u_fmt (
        .clk         (clk),
        .rst         (rst),
        .result      (result),
        .format_sel  (result_format_select),
        .result_high (res_high),
        .result_low  (res_low)
    );

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    wire [7:0] ctrl_view = {start_bit, conversion_busy_flag, conv_en,
                            result_format_select, external_channel_field};
    wire [7:0] src_view  = {signal_source_field, 1'b0, clkdiv};
    wire [7:0] ar        = s_axi_araddr;
    wire       ar_fire   = s_axi_arvalid & s_axi_arready;
    logic [31:0] rd_word;
    logic        rd_known;

    always_comb begin
        rd_word  = 32'h0000_0000;
        rd_known = 1'b1;
        case (ar)
            adcris_pkg::OFS_RESULT_LOW:   rd_word[7:0] = res_low;  // R1
            adcris_pkg::OFS_RESULT_HIGH:  rd_word[7:0] = res_high; // R1
            adcris_pkg::OFS_CONTROL_MAIN: rd_word[7:0] = ctrl_view;
            adcris_pkg::OFS_SOURCE_CLOCK: rd_word[7:0] = src_view;
            adcris_pkg::OFS_AMP_REF:      rd_word[7:0] = amp_ref;
            adcris_pkg::OFS_BANDGAP:      rd_word[0]   = bandgap;
            adcris_pkg::OFS_PIN_ASSIGN:   rd_word[NUM_PINS-1:0] = analog_input_pin;
            default:                      rd_known = 1'b0;
        endcase
    end

    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= adcris_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_known ? adcris_pkg::RESP_OKAY : adcris_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------
    wire [3:0] src = signal_source_field;

    assign sel_ground      = (src[3:2] == 2'b10);                        // R13
    assign sel_supply      = ~src[3] & ~src[2] & (src[1:0] != 2'b00);   // R13
    assign sel_amp         = ~src[3] & src[2] & (src[1:0] != 2'b00);    // R13
    assign sel_external    = ~sel_ground & ~sel_supply & ~sel_amp;      // R6 R13
    assign sel_divide_log2 = (sel_supply | sel_amp) ? src[1:0] - 2'd1 : 2'd0;
    assign converter_enable         = conv_en;
    assign conv_clock_divider_field = clkdiv;
    assign amp_enable_bit           = amp_ref[adcris_pkg::AMP_EN_BIT];
    assign amp_reference_output     = amp_ref[6:0];
    assign bandgap_enable_bit       = bandgap; // R9

    // ------------------------------------------------------------
    // Channel routing and pin takeover
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i++) begin : g_pin
            localparam logic [3:0] CODE = 4'(i);
            wire exists = (CODE != adcris_pkg::CHAN_RESERVED);
            assign channel_route[i]   = exists & sel_external
                                      & (external_channel_field == CODE); // R5 R12
            assign digital_connect[i] = ~analog_input_pin[i];               // R7
            assign pullup_enable[i]   = pullup_request[i] & ~analog_input_pin[i]; // R8
            chk_pullup_off: assert property (@(posedge clk) disable iff (rst) // R8
                analog_input_pin[i] |-> !pullup_enable[i])
                else $error("pull-up left on analog pin");
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_start_pulse;
        start_fall && wd_enable && !conversion_busy_flag;
    endsequence
    sequence s_complete;
        conversion_busy_flag && conv_done && conv_en;
    endsequence
    chk_start_busy: assert property ( // R10 R11
        s_start_pulse |=> conversion_busy_flag && conv_start)
        else $error("start sequence did not raise busy");
    chk_no_false_start: assert property ( // R10
        !conversion_busy_flag && !begin_conv |=> !conversion_busy_flag)
        else $error("busy rose without start sequence");
    chk_busy_clear: assert property ( // R11 R14
        s_complete |=> !conversion_busy_flag && result == $past(conv_data))
        else $error("completion did not clear busy or load result");
    chk_hold_disabled: assert property ( // R4
        !conv_en |=> $stable(result))
        else $error("result changed while disabled");
    chk_result_whole: assert property ( // R14
        !$stable(result) |-> $past(conversion_busy_flag) && !conversion_busy_flag)
        else $error("result changed outside completion");
    chk_digital_cut: assert property ( // R7
        (digital_connect & analog_input_pin) == '0)
        else $error("digital path left on analog pin");
    chk_chan_float: assert property ( // R12
        external_channel_field > adcris_pkg::CHAN_LAST
        || external_channel_field == adcris_pkg::CHAN_RESERVED |-> channel_route == '0)
        else $error("reserved or floating code routed a pin");
    chk_src_onehot: assert property ( // R6 R13
        $onehot({sel_external, sel_supply, sel_amp, sel_ground}))
        else $error("source decode not one-hot");
    chk_bandgap_bit: assert property ( // R9
        wr_bgap |=> bandgap_enable_bit == $past(wd[adcris_pkg::BANDGAP_BIT]))
        else $error("bandgap enable not taken");

endmodule

`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk, rst, awv, wv, bry, arv, rry, cdone;
    logic        awr, wrdy, bv, arr, rv, cst, sx, ss, sa, sg, bge;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd, d;
    logic [3:0]  ws;
    logic [11:0] cdata;
    logic [8:0]  preq, pen, dcon, route;
    logic [1:0]  br, rr, sdiv, r;
    logic        eg, es, ea, cen, aen;
    logic [2:0]  cdiv;
    logic [6:0]  aref;
    int          miscompares, n_checks, n_start, c;
    adcris_top uut (.clk(clk), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .s_axi_rdata(rd), .s_axi_rresp(rr), .conv_start(cst),
        .converter_enable(cen), .conv_done(cdone), .conv_data(cdata),
        .conv_clock_divider_field(cdiv), .channel_route(route), .sel_external(sx),
        .sel_supply(ss), .sel_amp(sa), .sel_ground(sg), .sel_divide_log2(sdiv),
        .amp_enable_bit(aen), .amp_reference_output(aref), .bandgap_enable_bit(bge),
        .pullup_request(preq), .pullup_enable(pen), .digital_connect(dcon));
    always #4 clk = ~clk;
    always @(posedge clk) if (cst === 1'b1) n_start <= n_start + 1;
    // ----------------------------------------
    // Report, check, bus and converter-pulse tasks
    // ----------------------------------------
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task ck(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic ah, wh, bh;
        awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        bh = 1'b0;
        for (int i = 0; i < 100 && !bh; i++) begin
            @(negedge clk);
            ah = awv & awr; wh = wv & wrdy; bh = bv; resp = br;
            @(posedge clk);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
        end
        bry <= 1'b0;
        if (!bh) begin
            miscompares++;
            final_report();
        end
        @(posedge clk);
    endtask
    task rdv(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        logic ah, rh;
        ara <= a; arv <= 1'b1; rry <= 1'b1;
        rh = 1'b0;
        for (int i = 0; i < 100 && !rh; i++) begin
            @(negedge clk);
            ah = arv & arr; rh = rv; v = rd; resp = rr;
            @(posedge clk);
            if (ah) arv <= 1'b0;
        end
        rry <= 1'b0;
        if (!rh) begin
            miscompares++;
            final_report();
        end
        @(posedge clk);
    endtask
    task wo(input logic [7:0] a, input logic [31:0] v);
        wr(a, v, r);
    endtask
    task rck(input logic [7:0] a, input logic [31:0] e);
        rdv(a, d, r);
        ck(d, e);
    endtask
    task pulse(input logic [11:0] v);
        cdone <= 1'b1; cdata <= v;
        @(posedge clk);
        cdone <= 1'b0; cdata <= ~v;
        @(posedge clk);
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        clk = 0; rst = 1; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0; cdone = 0;
        awa = 0; ara = 0; wd = 0; ws = 4'hf; cdata = 0; preq = 9'h1ff;
        miscompares = 0; n_checks = 0; n_start = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rck(8'h00, 32'h0);
        rck(8'h08, 32'h0);
        ck(pen, 9'h1ff);
        wr(8'h1c, 32'hff, r);
        ck(r, 2'h2);
        rdv(8'h1c, d, r);
        ck(d, 32'h0);
        ck(r, 2'h2);
        $display("test reset and decode done");
        wo(8'h08, 32'h20);
        rck(8'h08, 32'h20);
        ck(cen, 1'b1);
        ck(n_start, 0);
        wo(8'h08, 32'ha0);
        wo(8'h08, 32'h20);
        ck(n_start, 1);
        rck(8'h08, 32'h60);
        pulse(12'habc);
        rck(8'h08, 32'h20);
        rck(8'h04, 32'hab);
        rck(8'h00, 32'hc0);
        wo(8'h08, 32'h30);
        rck(8'h04, 32'h0a);
        rck(8'h00, 32'hbc);
        wo(8'h00, 32'hff);
        rck(8'h00, 32'hbc);
        wo(8'h08, 32'hb0);
        wo(8'h08, 32'h30);
        wo(8'h08, 32'h10);
        ck(cen, 1'b0);
        pulse(12'h123);
        rck(8'h08, 32'h10);
        rck(8'h00, 32'hbc);
        rck(8'h04, 32'h0a);
        $display("test conversion done");
        for (c = 0; c < 16; c++) begin
            wo(8'h0c, 32'h0);
            wo(8'h08, c);
            ck(route, (c <= 8 && c != 2) ? (9'h1 << c) : 9'h0);
            wo(8'h0c, c << 4);
            eg = (c[3:2] == 2'b10);
            es = (c >= 1 && c <= 3);
            ea = (c >= 5 && c <= 7);
            ck({sx, ss, sa, sg, sdiv}, {!(eg | es | ea), es, ea, eg,
                (es | ea) ? 2'(c[1:0] - 1) : 2'h0});
        end
        wo(8'h0c, 32'hff);
        rck(8'h0c, 32'hf7);
        ck(cdiv, 3'h7);
        wo(8'h10, 32'hff);
        rck(8'h10, 32'h9f);
        ck({aen, aref}, 8'h9f);
        $display("test routing done");
        wo(8'h18, 32'h105);
        ck(pen, 9'h0fa);
        ck(dcon, 9'h0fa);
        preq <= 9'h155;
        ws <= 4'h2;
        wo(8'h18, 32'h0);
        ws <= 4'hf;
        rck(8'h18, 32'h5);
        ck(pen, 9'h150);
        ck(dcon, 9'h1fa);
        wo(8'h14, 32'h1);
        ck(bge, 1'b1);
        rck(8'h14, 32'h1);
        wo(8'h14, 32'h0);
        ck(bge, 1'b0);
        $display("test pins and bandgap done");
        final_report();
    end
endmodule
`default_nettype wire
